// *** core/cam_alarm_match.sv ***
// alarm comparison unit with apb register access and interrupt
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module cam_alarm_match (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // live time counters, BCD, and their increment strobe
  input wire logic time_tick,
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hr,
  input wire logic [7:0] cur_dom,
  input wire logic [7:0] cur_dow,
  // alarm outputs
  output logic match_flag,
  output logic irq
);

  logic sec_match_disable_ff, min_match_disable_ff, hr_match_disable_ff;
  logic dom_match_disable_ff, dow_match_disable_ff;
  logic [6:0] sec_val_ff, min_val_ff, hr_val_ff, dom_val_ff, dow_val_ff;
  logic hr12_ff;
  logic stat_ff, mask_ff;
  logic match_prev_ff;
  logic wr_en, rd_en, mapped, stat_clr;
  logic any_en, all_match, match_event;
  logic [7:0] rd_byte;
  logic [7:0] sec_reg, min_reg, hr_reg, dom_reg, dow_reg;

  // one field compares equal, or is left out when disabled;
  // the disable bit itself never takes part in the comparison
  function automatic logic field_ok(input logic dis, input logic [7:0] want,
                                    input logic [7:0] now,
                                    input logic [7:0] impl);
    logic [7:0] cmp;
    cmp = impl;
    cmp[cam_pkg::DIS_BIT] = 1'b0;
    field_ok = dis | ((want & cmp) == (now & cmp));
  endfunction : field_ok

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;

  // readback views; the disable bit sits on top of the value bits
  assign sec_reg = {sec_match_disable_ff, sec_val_ff} & cam_pkg::SEC_IMPL;
  assign min_reg = {min_match_disable_ff, min_val_ff} & cam_pkg::MIN_IMPL;
  assign hr_reg = {hr_match_disable_ff, hr_val_ff} & cam_pkg::HR_IMPL;
  assign dom_reg = {dom_match_disable_ff, dom_val_ff} & cam_pkg::DOM_IMPL;
  assign dow_reg = {dow_match_disable_ff, dow_val_ff} & cam_pkg::DOW_IMPL;

  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      cam_pkg::SEC_ADDR: rd_byte = sec_reg;
      cam_pkg::MIN_ADDR: rd_byte = min_reg;
      cam_pkg::HR_ADDR: rd_byte = hr_reg;
      cam_pkg::DOM_ADDR: rd_byte = dom_reg;
      cam_pkg::DOW_ADDR: rd_byte = dow_reg;
      cam_pkg::CTRL_ADDR: rd_byte = {7'h00, hr12_ff};
      cam_pkg::STAT_ADDR: rd_byte = {7'h00, stat_ff};
      cam_pkg::MASK_ADDR: rd_byte = {7'h00, mask_ff};
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= cam_pkg::ZERO32;
    end else if (rd_en) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // disable bits come up set at every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_match_disable_ff <= 1'b1;
      min_match_disable_ff <= 1'b1;
      hr_match_disable_ff <= 1'b1;
      dom_match_disable_ff <= 1'b1;
      dow_match_disable_ff <= 1'b1;
    end else if (wr_en) begin
      unique case (paddr)
        cam_pkg::SEC_ADDR: sec_match_disable_ff <= pwdata[cam_pkg::DIS_BIT];
        cam_pkg::MIN_ADDR: min_match_disable_ff <= pwdata[cam_pkg::DIS_BIT];
        cam_pkg::HR_ADDR: hr_match_disable_ff <= pwdata[cam_pkg::DIS_BIT];
        cam_pkg::DOM_ADDR: dom_match_disable_ff <= pwdata[cam_pkg::DIS_BIT];
        cam_pkg::DOW_ADDR: dow_match_disable_ff <= pwdata[cam_pkg::DIS_BIT];
        default: ;
      endcase
    end
  end

  // value fields have no reset so they survive later resets
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      unique case (paddr)
        cam_pkg::SEC_ADDR: sec_val_ff <= pwdata[6:0] & cam_pkg::SEC_IMPL[6:0];
        cam_pkg::MIN_ADDR: min_val_ff <= pwdata[6:0] & cam_pkg::MIN_IMPL[6:0];
        cam_pkg::HR_ADDR: hr_val_ff <= pwdata[6:0] & cam_pkg::HR_IMPL[6:0];
        cam_pkg::DOM_ADDR: dom_val_ff <= pwdata[6:0] & cam_pkg::DOM_IMPL[6:0];
        cam_pkg::DOW_ADDR: dow_val_ff <= pwdata[6:0] & cam_pkg::DOW_IMPL[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hr12_ff <= 1'b0;
      mask_ff <= 1'b0;
    end else if (wr_en) begin
      if (paddr == cam_pkg::CTRL_ADDR) begin
        hr12_ff <= pwdata[cam_pkg::H12_BIT];
      end
      if (paddr == cam_pkg::MASK_ADDR) begin
        mask_ff <= pwdata[cam_pkg::FLAG_BIT];
      end
    end
  end

  // comparison; the hour compares bits 5:0 under either 12/24 select
  always_comb begin
    any_en = ~(sec_match_disable_ff & min_match_disable_ff &
               hr_match_disable_ff & dom_match_disable_ff &
               dow_match_disable_ff);
    all_match = any_en
      & field_ok(sec_match_disable_ff, sec_reg, cur_sec, cam_pkg::SEC_IMPL)
      & field_ok(min_match_disable_ff, min_reg, cur_min, cam_pkg::MIN_IMPL)
      & field_ok(hr_match_disable_ff, hr_reg, cur_hr,
                 hr12_ff ? (cam_pkg::HR12_VAL | (8'h01 << cam_pkg::PM_BIT))
                         : cam_pkg::HR_IMPL)
      & field_ok(dom_match_disable_ff, dom_reg, cur_dom, cam_pkg::DOM_IMPL)
      & field_ok(dow_match_disable_ff, dow_reg, cur_dow,
                 cam_pkg::DOW_IMPL);
  end

  // remember the result of the last evaluated tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_ff <= 1'b0;
    end else if (time_tick) begin
      match_prev_ff <= all_match;
    end
  end

  assign match_event = time_tick & all_match & ~match_prev_ff;
  assign stat_clr = wr_en & (paddr == cam_pkg::STAT_ADDR)
                    & pwdata[cam_pkg::FLAG_BIT];

  // sticky flag, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= 1'b0;
    end else if (match_event) begin
      stat_ff <= 1'b1;
    end else if (stat_clr) begin
      stat_ff <= 1'b0;
    end
  end

  assign match_flag = stat_ff;
  assign irq = stat_ff & mask_ff;

  // flag behaviour
  AST_FLAG_SETS: assert property (
    @(posedge pclk) disable iff (!presetn)
    match_event
    |=> stat_ff)
    else $error("flag not set on match");

  AST_FLAG_HOLDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    stat_ff && !stat_clr
    |=> stat_ff)
    else $error("flag dropped without clear");

  AST_FLAG_CLEARS: assert property (
    @(posedge pclk) disable iff (!presetn)
    stat_clr && !match_event
    |=> !stat_ff)
    else $error("flag not cleared by write");

  AST_NO_RESET_NOMATCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(stat_ff)
    |-> $past(time_tick) && !$past(match_prev_ff))
    else $error("flag set without fresh match");

  AST_NO_SET_IDLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !stat_ff && !time_tick
    |=> !stat_ff)
    else $error("flag set without a tick");

  AST_IRQ: assert property (
    @(posedge pclk) disable iff (!presetn)
    stat_ff || mask_ff || irq
    |-> irq == (stat_ff && mask_ff))
    else $error("irq mismatch");

  // match event
  AST_NO_ENABLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !any_en
    |-> !match_event)
    else $error("event with all disabled");

  AST_EVENT_PULSE: assert property (
    @(posedge pclk) disable iff (!presetn)
    match_event
    |=> !match_event)
    else $error("event repeated while match held");

  AST_PREV_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    !time_tick
    |=> $stable(match_prev_ff))
    else $error("match history moved without a tick");

  AST_PREV_FOLLOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    time_tick
    |=> match_prev_ff == $past(all_match))
    else $error("match history not taken on a tick");

  AST_HELD_MATCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    time_tick && match_prev_ff
    |-> !match_event)
    else $error("event while match persists");

  // field comparison
  AST_SEC_DIS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sec_match_disable_ff && all_match
    |-> sec_reg[6:0] == cur_sec[6:0])
    else $error("second ignored while enabled");

  AST_MIN_DIS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !min_match_disable_ff && all_match
    |-> min_reg[6:0] == cur_min[6:0])
    else $error("minute ignored while enabled");

  AST_HR_DIS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !hr_match_disable_ff && all_match && !hr12_ff
    |-> hr_reg[5:0] == cur_hr[5:0])
    else $error("hour ignored while enabled");

  AST_HR12_CMP: assert property (
    @(posedge pclk) disable iff (!presetn)
    !hr_match_disable_ff && all_match && hr12_ff
    |-> hr_reg[5:0] == cur_hr[5:0])
    else $error("12-hour value or afternoon bit ignored");

  AST_HR_MISS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !hr_match_disable_ff && hr_reg[5:0] != cur_hr[5:0]
    |-> !all_match)
    else $error("match despite enabled hour differing");

  AST_DOM_DIS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !dom_match_disable_ff && all_match
    |-> dom_reg[5:0] == cur_dom[5:0])
    else $error("day ignored while enabled");

  AST_DOW_DIS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !dow_match_disable_ff && all_match
    |-> dow_reg[2:0] == cur_dow[2:0])
    else $error("weekday ignored while enabled");

  AST_MIN_ONLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_match_disable_ff && hr_match_disable_ff && dom_match_disable_ff
    && dow_match_disable_ff && !min_match_disable_ff
    && min_reg[6:0] == cur_min[6:0]
    |-> all_match)
    else $error("disabled field blocked the match");

  // register access
  AST_SEC_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cam_pkg::SEC_ADDR
    |=> sec_match_disable_ff == $past(pwdata[cam_pkg::DIS_BIT]))
    else $error("second disable bit not written");

  AST_MIN_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cam_pkg::MIN_ADDR
    |=> min_match_disable_ff == $past(pwdata[cam_pkg::DIS_BIT]))
    else $error("minute disable bit not written");

  AST_HR_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cam_pkg::HR_ADDR
    |=> hr_match_disable_ff == $past(pwdata[cam_pkg::DIS_BIT]))
    else $error("hour disable bit not written");

  AST_DOM_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cam_pkg::DOM_ADDR
    |=> dom_match_disable_ff == $past(pwdata[cam_pkg::DIS_BIT]))
    else $error("day disable bit not written");

  AST_DOW_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cam_pkg::DOW_ADDR
    |=> dow_match_disable_ff == $past(pwdata[cam_pkg::DIS_BIT]))
    else $error("weekday disable bit not written");

  AST_FMT_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cam_pkg::CTRL_ADDR
    |=> hr12_ff == $past(pwdata[cam_pkg::H12_BIT]))
    else $error("hour format select not written");

  AST_DOW_RDZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    dow_match_disable_ff || !dow_match_disable_ff
    |-> (dow_reg & ~cam_pkg::DOW_IMPL) == 8'h00)
    else $error("unused weekday bits not zero");

  AST_HR_RDZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    hr_match_disable_ff || !hr_match_disable_ff
    |-> (hr_reg & ~cam_pkg::HR_IMPL) == 8'h00)
    else $error("unused hour bit not zero");

  AST_DOM_RDZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    dom_match_disable_ff || !dom_match_disable_ff
    |-> (dom_reg & ~cam_pkg::DOM_IMPL) == 8'h00)
    else $error("unused day bit not zero");

  AST_RD_UPPER: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_en
    |=> prdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");

  AST_DIS_RST: assert property (
    @(posedge pclk)
    !presetn
    |=> presetn || (sec_match_disable_ff && min_match_disable_ff
        && hr_match_disable_ff && dom_match_disable_ff
        && dow_match_disable_ff))
    else $error("disable bits not set by reset");

endmodule : cam_alarm_match

// *** shared/cam_pkg.sv ***
// package: register map, field layout and constants of the alarm match unit
package cam_pkg;
  // register word indices, times four for the byte address (printed offsets are not multiples of four)
  localparam int unsigned SEC_IDX = 8'h0A;
  localparam int unsigned MIN_IDX = 8'h0B;
  localparam int unsigned HR_IDX = 8'h0C;
  localparam int unsigned DOM_IDX = 8'h0D;
  localparam int unsigned DOW_IDX = 8'h0E;
  localparam int unsigned CTRL_IDX = 8'h20;
  localparam int unsigned STAT_IDX = 8'h21;
  localparam int unsigned MASK_IDX = 8'h22;
  localparam logic [11:0] SEC_ADDR = 12'(SEC_IDX * 4);
  localparam logic [11:0] MIN_ADDR = 12'(MIN_IDX * 4);
  localparam logic [11:0] HR_ADDR = 12'(HR_IDX * 4);
  localparam logic [11:0] DOM_ADDR = 12'(DOM_IDX * 4);
  localparam logic [11:0] DOW_ADDR = 12'(DOW_IDX * 4);
  localparam logic [11:0] CTRL_ADDR = 12'(CTRL_IDX * 4);
  localparam logic [11:0] STAT_ADDR = 12'(STAT_IDX * 4);
  localparam logic [11:0] MASK_ADDR = 12'(MASK_IDX * 4);
  // field layout
  localparam int DIS_BIT = 7;
  localparam int PM_BIT = 5;
  localparam int H12_BIT = 0;
  localparam int FLAG_BIT = 0;
  // implemented bits of each match register
  localparam logic [7:0] SEC_IMPL = 8'hFF;
  localparam logic [7:0] MIN_IMPL = 8'hFF;
  localparam logic [7:0] HR_IMPL = 8'hBF;
  localparam logic [7:0] DOM_IMPL = 8'hBF;
  localparam logic [7:0] DOW_IMPL = 8'h87;
  localparam logic [7:0] HR12_VAL = 8'h1F;
  localparam logic [7:0] DIS_RST = 8'h80;
  localparam logic [7:0] VAL_RST = 8'h00;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : cam_pkg

// *** sim/cam_alarm_match_tb_top.sv ***
// self-checking bench for the alarm match unit, read results queued
`timescale 1ns/1ps
module cam_alarm_match_tb_top;
  logic pclk, presetn, psel, penable, pwrite, time_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, match_flag, irq;
  logic [7:0] cur_sec, cur_min, cur_hr, cur_dom, cur_dow;
  logic [33:0] exp_q [$];
  logic [11:0] adr [5] = '{cam_pkg::SEC_ADDR, cam_pkg::MIN_ADDR,
    cam_pkg::HR_ADDR, cam_pkg::DOM_ADDR, cam_pkg::DOW_ADDR};
  logic [7:0] imp [5] = '{cam_pkg::SEC_IMPL, cam_pkg::MIN_IMPL,
    cam_pkg::HR_IMPL, cam_pkg::DOM_IMPL, cam_pkg::DOW_IMPL};
  logic [7:0] v [5] = '{8'h45, 8'h30, 8'h23, 8'h31, 8'h06};
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  cam_alarm_match i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_tick(time_tick), .cur_sec(cur_sec), .cur_min(cur_min),
    .cur_hr(cur_hr), .cur_dom(cur_dom), .cur_dow(cur_dow),
    .match_flag(match_flag), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // note holds {pslverr, irq, prdata}
  task automatic rd(input logic [11:0] a, input logic [1:0] e,
                    input logic [31:0] d);
    exp_q.push_back({e, d});
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic tk(input logic [7:0] s, m, h, d, w);
    cur_sec <= s;
    cur_min <= m;
    cur_hr <= h;
    cur_dom <= d;
    cur_dow <= w;
    time_tick <= 1'b1;
    @(posedge pclk);
    time_tick <= 1'b0;
    @(posedge pclk);
  endtask : tk
  always @(negedge pclk) begin
    logic [1:0] ei;
    logic [11:0] ra;
    logic [33:0] note;
    if (psel && penable && !pwrite) begin
      ei = {pslverr, irq};
      ra = paddr;
      check({33'h0, pready}, 34'h1);
      @(posedge pclk iff pready);
      #1;
      note = 34'h3_FFFF_FFFF;
      if (exp_q.size() != 0) note = exp_q.pop_front();
      check({ei, prdata}, note);
      if (ra == cam_pkg::STAT_ADDR) begin
        check({33'h0, match_flag}, {33'h0, note[0]});
      end
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, time_tick} = 5'h00;
    {paddr, pwdata} = 44'h000_0000_0000;
    {cur_sec, cur_min, cur_hr, cur_dom, cur_dow} = 40'h00_0000_0000;
    void'($urandom(40006));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(cam_pkg::CTRL_ADDR, 2'b00, 32'h0000_0000);
    rd(cam_pkg::MASK_ADDR, 2'b00, 32'h0000_0000);
    tk(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'h00);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 32'hFFFF_FFFF);
      rd(adr[i], 2'b00, {24'h00_0000, imp[i]});
      wr(adr[i], {24'h00_0000, v[i]});
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rd(adr[i], 2'b00, {24'h0, 8'h80 | v[i]});
    tk(v[0], v[1], v[2], v[3], v[4]);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    wr(cam_pkg::MIN_ADDR, 32'h0000_0030);
    tk(8'($urandom), 8'h29, 8'($urandom), 8'($urandom), 8'h02);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    tk(8'($urandom), 8'h30, 8'($urandom), 8'($urandom), 8'h04);
    wr(cam_pkg::MASK_ADDR, 32'h0000_0001);
    rd(cam_pkg::STAT_ADDR, 2'b01, 32'h0000_0001);
    tk(8'($urandom), 8'h30, 8'($urandom), 8'($urandom), 8'h01);
    rd(cam_pkg::STAT_ADDR, 2'b01, 32'h0000_0001);
    wr(cam_pkg::STAT_ADDR, 32'h0000_0001);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    tk(8'h11, 8'h30, 8'h05, 8'h07, 8'h03);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    tk(8'h12, 8'h31, 8'h05, 8'h07, 8'h03);
    tk(8'h13, 8'h30, 8'h05, 8'h07, 8'h03);
    wr(cam_pkg::MASK_ADDR, 32'h0000_0000);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0001);
    wr(cam_pkg::STAT_ADDR, 32'h0000_0001);
    for (int i = 0; i < 5; i++) wr(adr[i], {24'h00_0000, v[i]});
    tk(v[0], v[1], v[2], v[3], 8'h05);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    tk(v[0], v[1], v[2], v[3], v[4]);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0001);
    wr(cam_pkg::STAT_ADDR, 32'h0000_0001);
    wr(cam_pkg::CTRL_ADDR, 32'h0000_0001);
    rd(cam_pkg::CTRL_ADDR, 2'b00, 32'h0000_0001);
    wr(cam_pkg::HR_ADDR, 32'h0000_0032);
    tk(v[0], v[1], 8'h12, v[3], v[4]);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0000);
    tk(v[0], v[1], 8'h32, v[3], v[4]);
    rd(cam_pkg::STAT_ADDR, 2'b00, 32'h0000_0001);
    rd(12'h3FC, 2'b10, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0) check(34'h0, 34'h1);
    finish_test();
  end
endmodule : cam_alarm_match_tb_top
